// ==== core/dma_addr_pkg.sv ====
package dma_addr_pkg;

	// ----------------------------------------------------------------
	// Register map, one aligned word per register
	// ----------------------------------------------------------------
	localparam logic [3:0][31:0] SRC_START_OFF = {32'h4b0000c0,
		32'h4b000080, 32'h4b000040, 32'h4b000000};
	localparam logic [3:0][31:0] SRC_CTRL_OFF = {32'h4b0000c4,
		32'h4b000084, 32'h4b000044, 32'h4b000004};
	localparam logic [3:0][31:0] DST_START_OFF = {32'h4b0000b8,
		32'h4b000088, 32'h4b000048, 32'h4b000008};
	localparam logic [3:0][31:0] DST_CTRL_OFF = {32'h4b0000cc,
		32'h4b00008c, 32'h4b00004c, 32'h4b00000c};
	localparam logic [3:0][31:0] XFER_CFG_OFF = {32'h4b0000e4,
		32'h4b0000a4, 32'h4b000064, 32'h4b000024};
	localparam logic [3:0][31:0] SRC_RUN_OFF = {32'h4b0000e8,
		32'h4b0000a8, 32'h4b000068, 32'h4b000028};
	localparam logic [3:0][31:0] DST_RUN_OFF = {32'h4b0000ec,
		32'h4b0000ac, 32'h4b00006c, 32'h4b00002c};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BUS_SIDE_BIT = 1;
	localparam int FIXED_BIT = 0;
	localparam int CFG_BURST_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [30:0] ADDR_RESET = 31'h0000_0000;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_SRC_START = 3'b001,
		SEL_SRC_CTRL = 3'b010,
		SEL_DST_START = 3'b011,
		SEL_DST_CTRL = 3'b100,
		SEL_CFG = 3'b101,
		SEL_SRC_RUN = 3'b110,
		SEL_DST_RUN = 3'b111
	} reg_sel_t;

	typedef struct packed {
		logic hit;
		logic [1:0] ch;
		reg_sel_t sel;
	} decode_t;

	typedef struct packed {
		logic [30:0] addr;
		logic on_periph;
	} endpoint_t;

endpackage : dma_addr_pkg

// ==== core/dma_channel_address_control.sv ====
// Contract
// - Source control bit 1 picks source bus
// - Destination control bit 1 picks destination bus
// - Bit 0 clear: address steps by size
// - Bit 0 set: burst steps, then restores
// - Destination start loads when running zero, ack
// - All settings read zero after reset
// - Source start loads when running zero, ack
// - Burst is four beats, unit is one
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Data FIFO between source reads and destination writes
// ----------------------------------------------------------------
module dma_data_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic i_clk, // System clock
	input wire logic i_reset, // Synchronous reset
	input wire logic i_in_valid, // Push request
	input wire logic [WIDTH-1:0] i_in_data, // Push data
	output logic o_in_ready, // Room for a word
	output logic o_out_valid, // Word available
	output logic [WIDTH-1:0] o_out_data, // Head word
	input wire logic i_out_ready // Pop request
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic full;
		logic empty;
	} fifo_state_t;

	fifo_state_t q, d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	// Flags are registered so the ready reaching the source is a flop
	always_comb begin
		d = q;
		push = i_in_valid && !q.full;
		pop = i_out_ready && !q.empty;
		if (push) d.wr = q.wr + 1'b1;
		if (pop) d.rd = q.rd + 1'b1;
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		d.full = (d.cnt == (AW+1)'(DEPTH));
		d.empty = (d.cnt == '0);
	end

	// State register; empty starts set
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '{wr: '0, rd: '0, cnt: '0, full: 1'b0, empty: 1'b1};
		end else begin
			q <= d;
		end
	end

	// Storage has no reset, only valid words are read
	always_ff @(posedge i_clk) begin
		if (push) mem[q.wr] <= i_in_data;
	end

	assign o_in_ready = !q.full;
	assign o_out_valid = !q.empty;
	assign o_out_data = mem[q.rd];
endmodule : dma_data_fifo

// ----------------------------------------------------------------
// Address controls for four channels with AXI4-Lite registers
// ----------------------------------------------------------------
module dma_channel_address_control (
	input wire logic i_clk, // 200 MHz clock
	input wire logic i_reset, // Synchronous, active high
	input wire logic [31:0] i_awaddr, // Write address
	input wire logic i_awvalid, // Write address valid
	output logic o_awready, // Write address ready
	input wire logic [31:0] i_wdata, // Write data
	input wire logic [3:0] i_wstrb, // Byte strobes
	input wire logic i_wvalid, // Write data valid
	output logic o_wready, // Write data ready
	output logic [1:0] o_bresp, // Write response
	output logic o_bvalid, // Write response valid
	input wire logic i_bready, // Write response ready
	input wire logic [31:0] i_araddr, // Read address
	input wire logic i_arvalid, // Read address valid
	output logic o_arready, // Read address ready
	output logic [31:0] o_rdata, // Read data
	output logic [1:0] o_rresp, // Read response
	output logic o_rvalid, // Read data valid
	input wire logic i_rready, // Read data ready
	input wire logic [3:0] i_ack, // Per channel acknowledge
	input wire logic [1:0] i_chan, // Channel being served
	input wire logic i_rd_valid, // Source read beat data valid
	input wire logic [31:0] i_rd_data, // Source read beat data
	output logic o_rd_ready, // FIFO can take a beat
	output logic o_wr_valid, // Destination beat valid
	output logic [31:0] o_wr_data, // Destination beat data
	input wire logic i_wr_ready, // Destination took the beat
	output dma_addr_pkg::endpoint_t o_src, // Source address, bus side
	output dma_addr_pkg::endpoint_t o_dst, // Dest address, bus side
	output logic [1:0] o_size, // Data size code
	output logic o_burst // Burst of four selected
);
	typedef struct packed {
		logic [3:0][30:0] src_start;
		logic [3:0][30:0] dst_start;
		logic [3:0][30:0] src_run;
		logic [3:0][30:0] dst_run;
		logic [3:0][1:0] src_ctrl;
		logic [3:0][1:0] dst_ctrl;
		logic [3:0][1:0] src_cnt;
		logic [3:0][1:0] dst_cnt;
		logic [3:0][2:0] cfg;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic aw_have;
		logic w_have;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic wr_valid;
		logic [31:0] wr_data;
		logic [1:0] ch;
		logic [1:0] size;
		logic burst;
		dma_addr_pkg::endpoint_t src_out;
		dma_addr_pkg::endpoint_t dst_out;
	} state_t;

	state_t q, d;
	dma_addr_pkg::decode_t rd_dec, wr_dec;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [31:0] fifo_out_data;
	logic src_beat, dst_beat;
	logic [30:0] cur_src, cur_dst, cur_step;
	logic cur_burst;

	// Map a byte address onto channel and register
	function automatic dma_addr_pkg::decode_t decode(input logic [31:0] a);
		dma_addr_pkg::decode_t r;
		r = '{hit: 1'b0, ch: 2'h0, sel: dma_addr_pkg::SEL_NONE};
		for (int c = 0; c < 4; c++) begin
			if (a == dma_addr_pkg::SRC_START_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_SRC_START};
			end else if (a == dma_addr_pkg::SRC_CTRL_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_SRC_CTRL};
			end else if (a == dma_addr_pkg::DST_START_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_DST_START};
			end else if (a == dma_addr_pkg::DST_CTRL_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_DST_CTRL};
			end else if (a == dma_addr_pkg::XFER_CFG_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_CFG};
			end else if (a == dma_addr_pkg::SRC_RUN_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_SRC_RUN};
			end else if (a == dma_addr_pkg::DST_RUN_OFF[c]) begin
				r = '{1'b1, 2'(c), dma_addr_pkg::SEL_DST_RUN};
			end
		end
		return r;
	endfunction : decode

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	// Size code to byte step; the spare code is taken as a word
	function automatic logic [30:0] step(input logic [1:0] size);
		case (size)
			2'h0: step = 31'h1;
			2'h1: step = 31'h2;
			default: step = 31'h4;
		endcase
	endfunction : step

	// Address after one beat, shared by both sides
	function automatic logic [30:0] next_addr(input logic [30:0] a,
		input logic fixed, input logic burst, input logic [1:0] cnt,
		input logic [30:0] s);
		if (!fixed) return a + s;
		if (!burst) return a;
		// Last beat undoes the three steps taken within the burst
		if (cnt == dma_addr_pkg::LAST_BEAT) return a - (s + s + s);
		return a + s;
	endfunction : next_addr

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	dma_data_fifo #(
		.WIDTH(dma_addr_pkg::DATA_W),
		.DEPTH(dma_addr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_in_valid(i_rd_valid),
		.i_in_data(i_rd_data),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(fifo_out_ready)
	);

	// Beats are counted where data really moves, so stalls hold address
	assign fifo_out_ready = !q.wr_valid || i_wr_ready;
	assign src_beat = i_rd_valid && fifo_in_ready;
	assign dst_beat = q.wr_valid && i_wr_ready;
	assign cur_src = q.src_run[i_chan];
	assign cur_dst = q.dst_run[i_chan];
	assign cur_step = step(q.cfg[i_chan][1:0]);
	assign cur_burst = q.cfg[i_chan][dma_addr_pkg::CFG_BURST_BIT];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		rd_dec = decode(i_araddr);
		wr_dec = decode(q.awaddr);
		// Address and data are taken independently, in either order
		if (i_awvalid && q.awready) begin
			d.awaddr = i_awaddr;
			d.aw_have = 1'b1;
		end
		if (i_wvalid && q.wready) begin
			d.wdata = i_wdata;
			d.wstrb = i_wstrb;
			d.w_have = 1'b1;
		end
		if (q.bvalid && i_bready) d.bvalid = 1'b0;
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = dma_addr_pkg::RESP_OKAY;
			case (wr_dec.sel)
				dma_addr_pkg::SEL_SRC_START: d.src_start[wr_dec.ch] =
					31'(merge({1'b0, q.src_start[wr_dec.ch]}, q.wdata, q.wstrb));
				dma_addr_pkg::SEL_SRC_CTRL: d.src_ctrl[wr_dec.ch] =
					2'(merge({30'h0, q.src_ctrl[wr_dec.ch]}, q.wdata, q.wstrb));
				dma_addr_pkg::SEL_DST_START: d.dst_start[wr_dec.ch] =
					31'(merge({1'b0, q.dst_start[wr_dec.ch]}, q.wdata, q.wstrb));
				dma_addr_pkg::SEL_DST_CTRL: d.dst_ctrl[wr_dec.ch] =
					2'(merge({30'h0, q.dst_ctrl[wr_dec.ch]}, q.wdata, q.wstrb));
				dma_addr_pkg::SEL_CFG: d.cfg[wr_dec.ch] =
					3'(merge({29'h0, q.cfg[wr_dec.ch]}, q.wdata, q.wstrb));
				dma_addr_pkg::SEL_SRC_RUN,
				dma_addr_pkg::SEL_DST_RUN: d.bresp = dma_addr_pkg::RESP_OKAY;
				default: d.bresp = dma_addr_pkg::RESP_SLVERR;
			endcase
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		// Reads answer on the same edge that takes the address
		if (q.rvalid && i_rready) d.rvalid = 1'b0;
		if (i_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = dma_addr_pkg::RESP_OKAY;
			case (rd_dec.sel)
				dma_addr_pkg::SEL_SRC_START: d.rdata = {1'b0, q.src_start[rd_dec.ch]};
				dma_addr_pkg::SEL_SRC_CTRL: d.rdata = {30'h0, q.src_ctrl[rd_dec.ch]};
				dma_addr_pkg::SEL_DST_START: d.rdata = {1'b0, q.dst_start[rd_dec.ch]};
				dma_addr_pkg::SEL_DST_CTRL: d.rdata = {30'h0, q.dst_ctrl[rd_dec.ch]};
				dma_addr_pkg::SEL_CFG: d.rdata = {29'h0, q.cfg[rd_dec.ch]};
				dma_addr_pkg::SEL_SRC_RUN: d.rdata = {1'b0, q.src_run[rd_dec.ch]};
				dma_addr_pkg::SEL_DST_RUN: d.rdata = {1'b0, q.dst_run[rd_dec.ch]};
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = dma_addr_pkg::RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;
		if (src_beat) begin
			d.src_run[i_chan] = next_addr(cur_src,
				q.src_ctrl[i_chan][dma_addr_pkg::FIXED_BIT], cur_burst,
				q.src_cnt[i_chan], cur_step);
			d.src_cnt[i_chan] = cur_burst ? q.src_cnt[i_chan] + 2'h1 : 2'h0;
		end
		if (dst_beat) begin
			d.dst_run[i_chan] = next_addr(cur_dst,
				q.dst_ctrl[i_chan][dma_addr_pkg::FIXED_BIT], cur_burst,
				q.dst_cnt[i_chan], cur_step);
			d.dst_cnt[i_chan] = cur_burst ? q.dst_cnt[i_chan] + 2'h1 : 2'h0;
		end
		for (int c = 0; c < 4; c++) begin
			if (i_ack[c] && q.src_run[c] == '0) d.src_run[c] = q.src_start[c];
			if (i_ack[c] && q.dst_run[c] == '0) d.dst_run[c] = q.dst_start[c];
		end
		// Skid stage so the write port comes from flops
		if (fifo_out_valid && fifo_out_ready) begin
			d.wr_valid = 1'b1;
			d.wr_data = fifo_out_data;
		end else if (i_wr_ready) begin
			d.wr_valid = 1'b0;
		end
		d.ch = i_chan;
		d.src_out = {d.src_run[i_chan],
			d.src_ctrl[i_chan][dma_addr_pkg::BUS_SIDE_BIT]};
		d.dst_out = {d.dst_run[i_chan],
			d.dst_ctrl[i_chan][dma_addr_pkg::BUS_SIDE_BIT]};
		// Size and burst registered so the outputs leave a flop directly
		d.size = d.cfg[i_chan][1:0];
		d.burst = d.cfg[i_chan][dma_addr_pkg::CFG_BURST_BIT];
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register, except o_rd_ready which comes from the FIFO full flag
	assign o_awready = q.awready;
	assign o_wready = q.wready;
	assign o_bresp = q.bresp;
	assign o_bvalid = q.bvalid;
	assign o_arready = q.arready;
	assign o_rdata = q.rdata;
	assign o_rresp = q.rresp;
	assign o_rvalid = q.rvalid;
	assign o_rd_ready = fifo_in_ready;
	assign o_wr_valid = q.wr_valid;
	assign o_wr_data = q.wr_data;
	assign o_src = q.src_out;
	assign o_dst = q.dst_out;
	assign o_size = q.size;
	assign o_burst = q.burst;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_src_step;
		src_beat && cur_src != '0;
	endsequence
	sequence s_src_fixed_last;
		s_src_step ##0 q.src_ctrl[i_chan][dma_addr_pkg::FIXED_BIT] &&
			cur_burst && q.src_cnt[i_chan] == dma_addr_pkg::LAST_BEAT;
	endsequence

	property p_src_side;
		o_src.on_periph == q.src_ctrl[q.ch][dma_addr_pkg::BUS_SIDE_BIT];
	endproperty
	a_src_side: assert property (p_src_side)
		else $error("source bus side differs from setting");

	property p_dst_side;
		o_dst.on_periph == q.dst_ctrl[q.ch][dma_addr_pkg::BUS_SIDE_BIT] &&
			o_dst.addr == q.dst_run[q.ch];
	endproperty
	a_dst_side: assert property (p_dst_side)
		else $error("destination bus side or address differs");

	property p_src_inc;
		s_src_step ##0 !q.src_ctrl[i_chan][dma_addr_pkg::FIXED_BIT] |=>
			q.src_run[q.ch] == 31'($past(cur_src) + $past(cur_step));
	endproperty
	a_src_inc: assert property (p_src_inc)
		else $error("incrementing source did not step by size");

	property p_src_restore;
		s_src_fixed_last |=> q.src_run[q.ch] ==
			31'($past(cur_src) - 3 * $past(cur_step));
	endproperty
	a_src_restore: assert property (p_src_restore)
		else $error("fixed source not restored after burst");

	property p_dst_unit_fixed;
		dst_beat && cur_dst != '0 && !cur_burst &&
			q.dst_ctrl[i_chan][dma_addr_pkg::FIXED_BIT] |=>
			q.dst_run[q.ch] == $past(cur_dst);
	endproperty
	a_dst_unit_fixed: assert property (p_dst_unit_fixed)
		else $error("fixed destination moved on unit beat");

	property p_dst_load;
		i_ack[i_chan] && cur_dst == '0 |=>
			q.dst_run[q.ch] == $past(q.dst_start[i_chan]);
	endproperty
	a_dst_load: assert property (p_dst_load)
		else $error("destination start not loaded");

	property p_reset_zero;
		@(posedge i_clk) disable iff (1'b0)
		i_reset |=> q.src_ctrl == '0 && q.dst_ctrl == '0 &&
			q.dst_start == '0 && q.src_start == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("settings not zero after reset");

	property p_src_load;
		i_ack[i_chan] && cur_src == '0 |=>
			q.src_run[q.ch] == $past(q.src_start[i_chan]);
	endproperty
	a_src_load: assert property (p_src_load)
		else $error("source start not loaded");

	property p_burst_wrap;
		s_src_fixed_last |=> q.src_cnt[q.ch] == 2'h0;
	endproperty
	a_burst_wrap: assert property (p_burst_wrap)
		else $error("beat count did not wrap after four");

	property p_dst_indep;
		src_beat && !dst_beat && cur_dst != '0 |=>
			q.dst_run[q.ch] == $past(cur_dst);
	endproperty
	a_dst_indep: assert property (p_dst_indep)
		else $error("destination moved on a source beat");

endmodule : dma_channel_address_control

`default_nettype wire

// ==== tb/dma_beat_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Far side: a source slave offering words and a sink slave taking them
// ----------------------------------------------------------------
module dma_beat_partner #(
	parameter logic [31:0] WORD_BASE = 32'h5a00_0000
) (
	input wire logic i_clk, // Clock
	input wire logic i_reset, // Synchronous reset
	input wire logic i_rd_ready, // Block can take a source word
	input wire logic i_wr_valid, // Block offers a destination word
	input wire logic i_slow, // Sink takes on every other cycle only
	input wire logic [7:0] i_src_limit, // Total source words to offer
	input wire logic [7:0] i_dst_limit, // Total sink words to take
	output logic o_rd_valid, // Source word valid
	output logic [31:0] o_rd_data, // Source word
	output logic o_wr_ready, // Sink ready
	output logic [7:0] o_src_count, // Source words taken so far
	output logic [7:0] o_dst_count // Sink words taken so far
);
	logic [7:0] src_n;
	logic [7:0] dst_n;
	logic phase_q;

	// Counts after this edge's handshakes, read by the clocked process
	assign src_n = o_src_count + 8'(o_rd_valid & i_rd_ready);
	assign dst_n = o_dst_count + 8'(o_wr_ready & i_wr_valid);

	// Offer is held until taken; idle data flips each cycle so a stale
	// word can never pass for a fresh one
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_src_count <= 8'h00;
			o_dst_count <= 8'h00;
			o_rd_valid <= 1'b0;
			o_rd_data <= 32'h0000_0000;
			o_wr_ready <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			o_src_count <= src_n;
			o_dst_count <= dst_n;
			phase_q <= ~phase_q;
			o_wr_ready <= (dst_n < i_dst_limit) && (!i_slow || phase_q);
			if (!o_rd_valid || i_rd_ready) begin
				o_rd_valid <= src_n < i_src_limit;
				o_rd_data <= (src_n < i_src_limit) ? WORD_BASE + 32'(src_n)
					: ~o_rd_data;
			end
		end
	end
endmodule : dma_beat_partner

`default_nettype wire

// ==== tb/dma_channel_address_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module dma_channel_address_control_tb;
	localparam logic [31:0] BASE = 32'h5a00_0000;
	localparam logic [31:0] UNMAPPED = 32'h4b00_0010;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
	logic [3:0] ack = 4'h0;
	logic [1:0] chan = 2'h0;
	logic [7:0] src_limit = 8'h00, dst_limit = 8'h00;
	logic awready, wready, bvalid, arready, rvalid, burst;
	logic rd_valid, rd_ready, wr_valid, wr_ready;
	logic [1:0] bresp, rresp, size, resp;
	logic [31:0] rdata, rd_data, wr_data, got;
	logic [7:0] src_count, dst_count;
	dma_addr_pkg::endpoint_t src, dst;
	int num_errors = 0;
	int samples_checked = 0;
	int wr_seen = 0;

	always #2.5 i_clk = ~i_clk;

	dma_channel_address_control dma_channel_address_control_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_ack(ack), .i_chan(chan),
		.i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_ready(rd_ready),
		.o_wr_valid(wr_valid), .o_wr_data(wr_data), .i_wr_ready(wr_ready),
		.o_src(src), .o_dst(dst), .o_size(size), .o_burst(burst));

	dma_beat_partner #(.WORD_BASE(BASE)) dma_beat_partner_inst (
		.i_clk(i_clk), .i_reset(i_reset), .i_rd_ready(rd_ready),
		.i_wr_valid(wr_valid), .i_slow(slow), .i_src_limit(src_limit),
		.i_dst_limit(dst_limit), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_wr_ready(wr_ready),
		.o_src_count(src_count), .o_dst_count(dst_count));

	// ----------------------------------------------------------------
	// Comparison, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] g, input logic [31:0] e,
		input string m);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, m,
				g, e);
		end
	endtask : check

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked,
			num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic timeout(input string m);
		num_errors++;
		$display("CHECK FAILED at %0t: no answer, %s", $time, m);
		give_verdict();
	endtask : timeout

	// Address and data offered together, each dropped once taken
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (n > 200) timeout("write");
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (n > 200) timeout("read");
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read

	task automatic rd_check(input logic [31:0] a, input logic [31:0] e,
		input string m);
		axi_read(a, got, resp);
		check({30'h0, resp}, 32'h0, m);
		check(got, e, m);
	endtask : rd_check

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		axi_write(a, d, resp);
		check({30'h0, resp}, 32'h0, "write response");
	endtask : wr

	// Two settle edges let the one-cycle address view catch up
	task automatic wait_counts(input logic [7:0] s, input logic [7:0] d);
		int n;
		for (n = 0; src_count !== s || dst_count !== d; n++) begin
			if (n > 600) timeout("beats");
			@(posedge i_clk);
		end
		repeat (2) @(posedge i_clk);
	endtask : wait_counts

	// Destination words must leave in the order the source gave them
	always @(posedge i_clk) begin
		if (!i_reset && wr_valid && wr_ready) begin
			check(wr_data, BASE + 32'(wr_seen), "word order");
			wr_seen++;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int c;
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		for (c = 0; c < 4; c++) begin
			rd_check(dma_addr_pkg::SRC_CTRL_OFF[c], 32'h0, "src ctl rst");
			rd_check(dma_addr_pkg::DST_START_OFF[c], 32'h0, "dst st rst");
			rd_check(dma_addr_pkg::DST_CTRL_OFF[c], 32'h0, "dst ctl rst");
			rd_check(dma_addr_pkg::SRC_START_OFF[c], 32'h0, "src st rst");
		end
		wr(dma_addr_pkg::SRC_CTRL_OFF[2], 32'hffff_ffff);
		rd_check(dma_addr_pkg::SRC_CTRL_OFF[2], 32'h3, "ctl width");
		wr(dma_addr_pkg::DST_START_OFF[3], 32'hffff_ffff);
		rd_check(dma_addr_pkg::DST_START_OFF[3], 32'h7fff_ffff, "dst");
		// An unmapped word is refused on both paths
		axi_write(UNMAPPED, 32'h1234_5678, resp);
		check({30'h0, resp}, {30'h0, dma_addr_pkg::RESP_SLVERR}, "unm wr");
		axi_read(UNMAPPED, got, resp);
		check({30'h0, resp}, {30'h0, dma_addr_pkg::RESP_SLVERR}, "unm rd");
		// Channel 0: fixed source on peripheral side, word bursts
		wr(dma_addr_pkg::SRC_START_OFF[0], 32'h0000_0100);
		wr(dma_addr_pkg::SRC_CTRL_OFF[0], 32'h0000_0003);
		wr(dma_addr_pkg::DST_START_OFF[0], 32'h0000_0200);
		wr(dma_addr_pkg::XFER_CFG_OFF[0], 32'h0000_0006);
		ack <= 4'h1;
		wr(dma_addr_pkg::DST_RUN_OFF[0], 32'h0000_0abc);
		rd_check(dma_addr_pkg::DST_RUN_OFF[0], 32'h200, "dst load");
		rd_check(dma_addr_pkg::SRC_RUN_OFF[0], 32'h100, "src load");
		check({31'h0, src.on_periph}, 32'h1, "source side");
		check({31'h0, dst.on_periph}, 32'h0, "dest side");
		check({29'h0, burst, size}, 32'h6, "size and burst");
		for (c = 1; c <= 4; c++) begin
			src_limit <= 8'(c);
			wait_counts(8'(c), 8'h00);
			check({1'b0, src.addr}, (c == 4) ? 32'h100 : 32'h100 + 32'(4 * c),
				"fixed burst beat");
		end
		dst_limit <= 8'h04;
		wait_counts(8'h04, 8'h04);
		check({1'b0, dst.addr}, 32'h210, "dest view");
		rd_check(dma_addr_pkg::DST_RUN_OFF[0], 32'h210, "dst steps");
		// Channel 1: byte units, the buffer fills against a stalled sink
		wr(dma_addr_pkg::SRC_START_OFF[1], 32'h0000_0301);
		wr(dma_addr_pkg::DST_START_OFF[1], 32'h0000_0400);
		wr(dma_addr_pkg::DST_CTRL_OFF[1], 32'h0000_0003);
		chan <= 2'h1;
		ack <= 4'h3;
		src_limit <= 8'd24;
		for (c = 0; rd_ready !== 1'b0; c++) begin
			if (c > 300) timeout("buffer full");
			@(posedge i_clk);
		end
		check({31'h0, src_count >= 8'd20}, 32'h1, "buffer depth");
		check({31'h0, src.on_periph}, 32'h0, "source side");
		check({31'h0, dst.on_periph}, 32'h1, "dest side");
		check({29'h0, burst, size}, 32'h0, "unit byte cfg");
		slow <= 1'b1;
		dst_limit <= 8'd24;
		wait_counts(8'd24, 8'd24);
		rd_check(dma_addr_pkg::SRC_RUN_OFF[1], 32'h315, "byte step");
		rd_check(dma_addr_pkg::DST_RUN_OFF[1], 32'h400, "fixed unit");
		check({1'b0, src.addr}, 32'h315, "source view");
		check({1'b0, dst.addr}, 32'h400, "dest view");
		// Channel 2: half-word units, fixed source, stepping destination
		wr(dma_addr_pkg::SRC_START_OFF[2], 32'h0000_0500);
		wr(dma_addr_pkg::DST_START_OFF[2], 32'h0000_0600);
		wr(dma_addr_pkg::XFER_CFG_OFF[2], 32'h0000_0001);
		chan <= 2'h2;
		ack <= 4'h7;
		src_limit <= 8'd28;
		dst_limit <= 8'd28;
		wait_counts(8'd28, 8'd28);
		check({29'h0, burst, size}, 32'h1, "half cfg");
		check({1'b0, dst.addr}, 32'h608, "half step");
		rd_check(dma_addr_pkg::SRC_RUN_OFF[2], 32'h500, "fixed src");
		check({31'h0, src.on_periph}, 32'h1, "source side");
		give_verdict();
	end
endmodule : dma_channel_address_control_tb

`default_nettype wire
